// [adcsp_params.svh]
/*
  constants of the converter serial port: bus offsets, field positions,
  reset values and counts. assumes inclusion by bare name.
*/
`ifndef ADCSP_PARAMS_SVH
`define ADCSP_PARAMS_SVH
// bus register byte offsets
`define ADCSP_OFF_SAMPLE 8'h00
`define ADCSP_OFF_STATUS 8'h04
`define ADCSP_OFF_COMM   8'h08
`define ADCSP_OFF_SETUP  8'h0C
`define ADCSP_OFF_CLOCK  8'h10
// status register bit positions
`define ADCSP_ST_RDY 0
`define ADCSP_ST_CAL 1
`define ADCSP_ST_RD  2
`define ADCSP_ST_WR  3
// communication byte fields
`define ADCSP_COMM_RS_MSB 6
`define ADCSP_COMM_RS_LSB 4
`define ADCSP_COMM_RW_BIT 3
// register select codes
`define ADCSP_RS_COMM  3'h0
`define ADCSP_RS_SETUP 3'h1
`define ADCSP_RS_CLOCK 3'h2
`define ADCSP_RS_DATA  3'h3
`define ADCSP_RS_OFFS  3'h6
`define ADCSP_RS_GAIN  3'h7
// setup mode field and self calibration code
`define ADCSP_SETUP_MD_MSB 7
`define ADCSP_SETUP_MD_LSB 6
`define ADCSP_MD_SELF_CAL  2'h1
// transfer lengths in bits
`define ADCSP_LEN_BYTE 5'h08
`define ADCSP_LEN_WORD 5'h10
`define ADCSP_LEN_WIDE 5'h18
// consecutive ones that reset the port
`define ADCSP_ONES_RESET 6'h20
// reset values
`define ADCSP_RST_REG  24'h000000
`define ADCSP_RST_COMM 8'h00
`define ADCSP_RST_DATA 16'h0000
// bus responses
`define ADCSP_RESP_OKAY   2'h0
`define ADCSP_RESP_SLVERR 2'h2
`endif

// [adcsp_pkg.sv]
/*
  types of the converter serial port.
  assumes nothing of its surroundings.
*/
`default_nettype none
package adcsp_pkg;
  // serial port phase
  typedef enum logic [1:0] {ST_COMM, ST_WRITE, ST_READ} adcsp_state_t;
  // bus read phase
  typedef enum logic [1:0] {RD_IDLE, RD_ADDR, RD_DATA, RD_RESP} adcsp_rdst_t;
endpackage : adcsp_pkg
`default_nettype wire

// [adcsp_regmem.sv]
/*
  small register memory with one write port and two registered read ports.
  assumes one clock; reads appear one cycle after the address.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adcsp_params.svh"
module adcsp_regmem #(
  parameter int W = 24,
  parameter int D = 8,
  parameter int A = 3
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic         i_we,
  input  wire logic [A-1:0] i_waddr,
  input  wire logic [W-1:0] i_wdata,
  input  wire logic [A-1:0] i_raddr_a,
  output logic      [W-1:0] o_rdata_a,
  input  wire logic [A-1:0] i_raddr_b,
  output logic      [W-1:0] o_rdata_b
);
  logic [W-1:0] mem_q [D];
  logic [W-1:0] mem_d [D];
  logic [W-1:0] ra_d;
  logic [W-1:0] rb_d;

  // next contents and read words
  always_comb begin
    mem_d = mem_q;
    if (i_we) begin
      mem_d[i_waddr] = i_wdata;
    end
    ra_d = mem_q[i_raddr_a];
    rb_d = mem_q[i_raddr_b];
  end

  // storage and read registers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < D; i++) begin
        mem_q[i] <= `ADCSP_RST_REG;
      end
      o_rdata_a <= `ADCSP_RST_REG;
      o_rdata_b <= `ADCSP_RST_REG;
    end else begin
      mem_q     <= mem_d;
      o_rdata_a <= ra_d;
      o_rdata_b <= rb_d;
    end
  end
endmodule : adcsp_regmem
`default_nettype wire

// [adcsp_top.sv]
/*
  serial register port of a sigma-delta converter, device side, with an
  axi4-lite slave for the converter core. assumes sclk, din and cs_n are
  synchronous to i_ref_clk and that sclk is much slower than it.
*/
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "adcsp_params.svh"
module adcsp_top #(
  parameter int AW = 8
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  input  wire logic          i_sclk,
  input  wire logic          i_din,
  input  wire logic          i_cs_n,
  output logic               o_dout,
  output logic               o_dout_oe_n,
  output logic               o_result_ready_n,
  input  wire logic [AW-1:0] i_s_axi_awaddr,
  input  wire logic          i_s_axi_awvalid,
  output logic               o_s_axi_awready,
  input  wire logic [31:0]   i_s_axi_wdata,
  input  wire logic [3:0]    i_s_axi_wstrb,
  input  wire logic          i_s_axi_wvalid,
  output logic               o_s_axi_wready,
  output logic [1:0]         o_s_axi_bresp,
  output logic               o_s_axi_bvalid,
  input  wire logic          i_s_axi_bready,
  input  wire logic [AW-1:0] i_s_axi_araddr,
  input  wire logic          i_s_axi_arvalid,
  output logic               o_s_axi_arready,
  output logic [31:0]        o_s_axi_rdata,
  output logic [1:0]         o_s_axi_rresp,
  output logic               o_s_axi_rvalid,
  input  wire logic          i_s_axi_rready
);
  // transfer length of a selected register
  function automatic logic [4:0] reg_len(input logic [2:0] rs);
    if (rs == `ADCSP_RS_DATA) begin
      return `ADCSP_LEN_WORD;
    end else if (rs == `ADCSP_RS_OFFS || rs == `ADCSP_RS_GAIN) begin
      return `ADCSP_LEN_WIDE;
    end
    return `ADCSP_LEN_BYTE;
  endfunction : reg_len

  adcsp_pkg::adcsp_state_t state_q, state_d;
  adcsp_pkg::adcsp_rdst_t  rdst_q, rdst_d;
  logic        sclk_prev_q;
  logic [4:0]  bitcnt_q, bitcnt_d, len_q, len_d;
  logic [2:0]  rs_q, rs_d;
  logic [7:0]  comm_q, comm_d;
  logic [23:0] in_sr_q, in_sr_d, out_sr_q, out_sr_d, in_word, rd_word;
  logic [5:0]  ones_q, ones_d;
  logic        dout_q, dout_d, oe_n_q, oe_n_d;
  logic        rise, fall, mem_we, data_rd_done, cal_set;
  logic [23:0] mem_wdata, mem_ra, mem_rb;
  logic [15:0] data_q, data_d, pend_q, pend_d;
  logic        ready_q, ready_d, upd_q, upd_d, cal_q, cal_d, rdy_n_q, rdy_n_d;
  logic        awr_q, awr_d, wr_q, wr_d, awg_q, awg_d, wg_q, wg_d;
  logic        bv_q, bv_d, wr_sample, wr_status;
  logic [AW-1:0] awa_q, awa_d, ara_q, ara_d;
  logic [31:0] wd_q, wd_d, rdata_q, rdata_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        arr_q, arr_d, rv_q, rv_d;
  logic [2:0]  rb_addr;

  adcsp_regmem #(.W(24), .D(8), .A(3)) u_mem (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_we      (mem_we),
    .i_waddr   (rs_q),
    .i_wdata   (mem_wdata),
    .i_raddr_a (rs_q),
    .o_rdata_a (mem_ra),
    .i_raddr_b (rb_addr),
    .o_rdata_b (mem_rb)
  );

  // edges seen only while selected
  assign rise    = i_sclk & ~sclk_prev_q & ~i_cs_n;
  assign fall    = ~i_sclk & sclk_prev_q & ~i_cs_n;
  assign in_word = {in_sr_q[22:0], i_din};
  assign rb_addr = (ara_q == `ADCSP_OFF_CLOCK) ? `ADCSP_RS_CLOCK : `ADCSP_RS_SETUP;

  // word to send, left aligned so the msb leaves first
  always_comb begin
    if (rs_q == `ADCSP_RS_DATA) begin
      rd_word = {data_q, 8'h00};
    end else if (rs_q == `ADCSP_RS_COMM) begin
      rd_word = {~ready_q, comm_q[6:0], 16'h0000};
    end else if (len_q == `ADCSP_LEN_WIDE) begin
      rd_word = mem_ra;
    end else begin
      rd_word = {mem_ra[7:0], 16'h0000};
    end
  end

  // serial port sequencing
  always_comb begin
    state_d = state_q;
    bitcnt_d = bitcnt_q;
    len_d = len_q;
    rs_d = rs_q;
    comm_d = comm_q;
    in_sr_d = in_sr_q;
    out_sr_d = out_sr_q;
    ones_d = ones_q;
    dout_d = dout_q;
    oe_n_d = oe_n_q;
    mem_we = 1'b0;
    mem_wdata = (len_q == `ADCSP_LEN_WIDE) ? in_word : {16'h0000, in_word[7:0]};
    data_rd_done = 1'b0;
    cal_set = 1'b0;
    if (rise && state_q != adcsp_pkg::ST_READ) begin
      ones_d = i_din ? ones_q + 6'h01 : 6'h00;
    end
    if (rise && state_q != adcsp_pkg::ST_READ && i_din
        && ones_q == `ADCSP_ONES_RESET - 6'h01) begin
      state_d = adcsp_pkg::ST_COMM;
      bitcnt_d = 5'h00;
      ones_d = 6'h00;
    end else begin
      unique case (state_q)
        adcsp_pkg::ST_COMM: begin
          if (rise) begin
            in_sr_d = in_word;
            bitcnt_d = bitcnt_q + 5'h01;
            if (bitcnt_q == `ADCSP_LEN_BYTE - 5'h01) begin
              // comm byte names target and direction
              comm_d = in_word[7:0];
              rs_d = in_word[`ADCSP_COMM_RS_MSB:`ADCSP_COMM_RS_LSB];
              len_d = reg_len(rs_d);
              bitcnt_d = 5'h00;
              if (in_word[`ADCSP_COMM_RW_BIT]) begin
                state_d = adcsp_pkg::ST_READ;
              end else if (rs_d != `ADCSP_RS_COMM) begin
                state_d = adcsp_pkg::ST_WRITE;
              end
            end
          end
        end
        adcsp_pkg::ST_WRITE: begin
          if (rise) begin
            in_sr_d = in_word;
            bitcnt_d = bitcnt_q + 5'h01;
            if (bitcnt_q == len_q - 5'h01) begin
              mem_we = (rs_q != `ADCSP_RS_DATA);
              cal_set = (rs_q == `ADCSP_RS_SETUP) && (in_word[`ADCSP_SETUP_MD_MSB:
                `ADCSP_SETUP_MD_LSB] == `ADCSP_MD_SELF_CAL);
              bitcnt_d = 5'h00;
              state_d = adcsp_pkg::ST_COMM;
            end
          end
        end
        adcsp_pkg::ST_READ: begin
          // din is not shifted here
          if (fall) begin
            oe_n_d = 1'b0;
            if (bitcnt_q == 5'h00) begin
              dout_d = rd_word[23];
              out_sr_d = {rd_word[22:0], 1'b0};
            end else begin
              dout_d = out_sr_q[23];
              out_sr_d = {out_sr_q[22:0], 1'b0};
            end
          end
          if (rise) begin
            bitcnt_d = bitcnt_q + 5'h01;
            if (bitcnt_q == len_q - 5'h01) begin
              data_rd_done = (rs_q == `ADCSP_RS_DATA);
              bitcnt_d = 5'h00;
              state_d = adcsp_pkg::ST_COMM;
            end
          end
        end
      endcase
    end
    if (state_d != adcsp_pkg::ST_READ) begin
      oe_n_d = 1'b1;
    end
  end

  // serial port registers
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= adcsp_pkg::ST_COMM;
      sclk_prev_q <= 1'b1;
      bitcnt_q <= 5'h00;
      len_q <= `ADCSP_LEN_BYTE;
      rs_q <= `ADCSP_RS_COMM;
      comm_q <= `ADCSP_RST_COMM;
      in_sr_q <= `ADCSP_RST_REG;
      out_sr_q <= `ADCSP_RST_REG;
      ones_q <= 6'h00;
      dout_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      sclk_prev_q <= i_sclk;
      bitcnt_q <= bitcnt_d;
      len_q <= len_d;
      rs_q <= rs_d;
      comm_q <= comm_d;
      in_sr_q <= in_sr_d;
      out_sr_q <= out_sr_d;
      ones_q <= ones_d;
      dout_q <= dout_d;
      oe_n_q <= oe_n_d;
    end
  end

  // result register, ready flag and calibration flag
  always_comb begin
    data_d = data_q;
    pend_d = pend_q;
    upd_d = 1'b0;
    ready_d = ready_q & ~data_rd_done;
    if (wr_sample) begin
      pend_d[7:0] = ws_q[0] ? wd_q[7:0] : data_q[7:0];
      pend_d[15:8] = ws_q[1] ? wd_q[15:8] : data_q[15:8];
      upd_d = 1'b1;
    end
    if (upd_q) begin
      data_d = pend_q;
      ready_d = 1'b1; // set wins over the read clear
    end
    rdy_n_d = ~ready_d | upd_d;
    cal_d = cal_set | (cal_q & ~(wr_status & ws_q[0] & wd_q[`ADCSP_ST_CAL]));
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      data_q <= `ADCSP_RST_DATA;
      pend_q <= `ADCSP_RST_DATA;
      upd_q <= 1'b0;
      ready_q <= 1'b0;
      rdy_n_q <= 1'b1;
      cal_q <= 1'b0;
    end else begin
      data_q <= data_d;
      pend_q <= pend_d;
      upd_q <= upd_d;
      ready_q <= ready_d;
      rdy_n_q <= rdy_n_d;
      cal_q <= cal_d;
    end
  end

  // bus write: address and data in either order, then response
  always_comb begin
    awr_d = awr_q;
    wr_d = wr_q;
    awg_d = awg_q;
    wg_d = wg_q;
    awa_d = awa_q;
    wd_d = wd_q;
    ws_d = ws_q;
    bv_d = bv_q;
    bresp_d = bresp_q;
    wr_sample = 1'b0;
    wr_status = 1'b0;
    if (i_s_axi_awvalid && awr_q) begin
      awa_d = i_s_axi_awaddr;
      awg_d = 1'b1;
      awr_d = 1'b0;
    end
    if (i_s_axi_wvalid && wr_q) begin
      wd_d = i_s_axi_wdata;
      ws_d = i_s_axi_wstrb;
      wg_d = 1'b1;
      wr_d = 1'b0;
    end
    if (awg_q && wg_q && !bv_q) begin
      wr_sample = (awa_q == `ADCSP_OFF_SAMPLE) && (ws_q[1:0] != 2'h0);
      wr_status = (awa_q == `ADCSP_OFF_STATUS);
      bresp_d = (awa_q == `ADCSP_OFF_SAMPLE || wr_status) ?
                `ADCSP_RESP_OKAY : `ADCSP_RESP_SLVERR;
      bv_d = 1'b1;
      awg_d = 1'b0;
      wg_d = 1'b0;
    end
    if (bv_q && i_s_axi_bready) begin
      bv_d = 1'b0;
      awr_d = 1'b1;
      wr_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      awr_q <= 1'b1;
      wr_q <= 1'b1;
      awg_q <= 1'b0;
      wg_q <= 1'b0;
      awa_q <= '0;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      bv_q <= 1'b0;
      bresp_q <= `ADCSP_RESP_OKAY;
    end else begin
      awr_q <= awr_d;
      wr_q <= wr_d;
      awg_q <= awg_d;
      wg_q <= wg_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      ws_q <= ws_d;
      bv_q <= bv_d;
      bresp_q <= bresp_d;
    end
  end

  // bus read: address, memory wait, data, response
  always_comb begin
    rdst_d = rdst_q;
    ara_d = ara_q;
    arr_d = arr_q;
    rv_d = rv_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    unique case (rdst_q)
      adcsp_pkg::RD_IDLE: begin
        if (i_s_axi_arvalid) begin
          ara_d = i_s_axi_araddr;
          arr_d = 1'b0;
          rdst_d = adcsp_pkg::RD_ADDR;
        end
      end
      adcsp_pkg::RD_ADDR: begin
        rdst_d = adcsp_pkg::RD_DATA;
      end
      adcsp_pkg::RD_DATA: begin
        rresp_d = `ADCSP_RESP_OKAY;
        rdata_d = 32'h00000000;
        unique case (ara_q)
          `ADCSP_OFF_SAMPLE: rdata_d[15:0] = data_q;
          `ADCSP_OFF_STATUS: begin
            rdata_d[`ADCSP_ST_RDY] = ready_q;
            rdata_d[`ADCSP_ST_CAL] = cal_q;
            rdata_d[`ADCSP_ST_RD] = (state_q == adcsp_pkg::ST_READ);
            rdata_d[`ADCSP_ST_WR] = (state_q == adcsp_pkg::ST_WRITE);
          end
          `ADCSP_OFF_COMM: rdata_d[7:0] = comm_q;
          `ADCSP_OFF_SETUP: rdata_d[7:0] = mem_rb[7:0];
          `ADCSP_OFF_CLOCK: rdata_d[7:0] = mem_rb[7:0];
          default: rresp_d = `ADCSP_RESP_SLVERR;
        endcase
        rv_d = 1'b1;
        rdst_d = adcsp_pkg::RD_RESP;
      end
      adcsp_pkg::RD_RESP: begin
        if (i_s_axi_rready) begin
          rv_d = 1'b0;
          arr_d = 1'b1;
          rdst_d = adcsp_pkg::RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdst_q <= adcsp_pkg::RD_IDLE;
      ara_q <= '0;
      arr_q <= 1'b1;
      rv_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `ADCSP_RESP_OKAY;
    end else begin
      rdst_q <= rdst_d;
      ara_q <= ara_d;
      arr_q <= arr_d;
      rv_q <= rv_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // outputs straight from flops
  assign o_dout           = dout_q;
  assign o_dout_oe_n      = oe_n_q;
  assign o_result_ready_n = rdy_n_q;
  assign o_s_axi_awready  = awr_q;
  assign o_s_axi_wready   = wr_q;
  assign o_s_axi_bvalid   = bv_q;
  assign o_s_axi_bresp    = bresp_q;
  assign o_s_axi_arready  = arr_q;
  assign o_s_axi_rvalid   = rv_q;
  assign o_s_axi_rdata    = rdata_q;
  assign o_s_axi_rresp    = rresp_q;
endmodule : adcsp_top
`default_nettype wire

// [adcsp_host_model.sv]
/*
  behavioural serial host that clocks bytes in and out of the converter port.
  assumes i_ref_clk at 25 MHz; one serial half period is HALF ref cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module adcsp_host_model #(
  parameter int HALF = 5
) (
  input  wire logic i_ref_clk,
  input  wire logic i_dout,
  input  wire logic i_dout_oe_n,
  output logic      o_sclk,
  output logic      o_din,
  output logic      o_cs_n
);
  // idle: clock parked high, port deselected
  initial begin
    o_sclk = 1'h1;
    o_din  = 1'h1;
    o_cs_n = 1'h1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : tick

  // n bits msb first, change on fall, capture on rise, 2.5 MHz clock
  task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
    int i;
    rx = 32'h0;
    @(posedge i_ref_clk);
    o_cs_n <= 1'h0;
    for (i = n - 1; i >= 0; i--) begin
      tick(HALF);
      o_sclk <= 1'h0;
      o_din  <= tx[i];
      tick(HALF);
      o_sclk <= 1'h1;
      rx = {rx[30:0], i_dout_oe_n ? 1'hX : i_dout};
    end
  endtask : shift

  // release select; the data line no longer holds its last value
  task automatic drop();
    @(posedge i_ref_clk);
    o_cs_n <= 1'h1;
    o_din  <= ~o_din;
    tick(HALF);
  endtask : drop
endmodule : adcsp_host_model
`default_nettype wire

// [adcsp_chk.sv]
/*
  concurrent checks on the ports of the converter serial port.
  assumes one clock i_ref_clk and active high async reset i_rst.
*/
`timescale 1ns/1ns
`default_nettype none
module adcsp_chk (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_sclk,
  input wire logic        i_cs_n,
  input wire logic        o_dout,
  input wire logic        o_dout_oe_n,
  input wire logic        o_result_ready_n,
  input wire logic        i_s_axi_awvalid,
  input wire logic        o_s_axi_awready,
  input wire logic        i_s_axi_wvalid,
  input wire logic        o_s_axi_wready,
  input wire logic        o_s_axi_bvalid,
  input wire logic        i_s_axi_bready,
  input wire logic        i_s_axi_arvalid,
  input wire logic        o_s_axi_arready,
  input wire logic        o_s_axi_rvalid,
  input wire logic        i_s_axi_rready
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_oe_on_fall: assert property ($fell(o_dout_oe_n) |-> !i_sclk && !i_cs_n)
    else $error("dout enabled outside a selected clock low phase");
  chk_dout_low_only: assert property (!o_dout_oe_n && $changed(o_dout) |-> !i_sclk)
    else $error("dout changed while serial clock high");
  chk_oe_off_rise: assert property ($rose(o_dout_oe_n) |-> i_sclk)
    else $error("dout released away from a rising edge");
  chk_ready_cause: assert property ($fell(o_result_ready_n) |->
      $past(o_s_axi_bvalid) || $past(o_s_axi_bvalid, 2) || $past(o_s_axi_bvalid, 3))
    else $error("ready pin fell without a result write");
  chk_b_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
      && o_s_axi_wready |-> ##[1:2] o_s_axi_bvalid)
    else $error("write response late");
  chk_b_release: assert property (o_s_axi_bvalid && i_s_axi_bready |=>
      !o_s_axi_bvalid && o_s_axi_awready && o_s_axi_wready)
    else $error("write response not retired");
  chk_w_refuse: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
    else $error("write taken while response pending");
  chk_r_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |-> ##[1:4] o_s_axi_rvalid)
    else $error("read data late");
  chk_r_release: assert property (o_s_axi_rvalid && i_s_axi_rready |=>
      !o_s_axi_rvalid && o_s_axi_arready)
    else $error("read data not retired");

  cov_ready: cover property ($fell(o_result_ready_n));
  cov_read: cover property ($fell(o_dout_oe_n));
  cov_bus_wr: cover property (o_s_axi_bvalid && i_s_axi_bready);
endmodule : adcsp_chk

bind adcsp_top adcsp_chk i_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
  .o_dout(o_dout), .o_dout_oe_n(o_dout_oe_n), .o_result_ready_n(o_result_ready_n),
  .i_s_axi_awvalid(i_s_axi_awvalid), .o_s_axi_awready(o_s_axi_awready),
  .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
  .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
  .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready)
);
`default_nettype wire

// [tb.sv]
/*
  self-checking bench: serial host model on one side, axi4-lite master on the other.
  assumes the register offsets and codes of adcsp_params.svh.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adcsp_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        sclk, din, cs_n, dout, oe_n, rdy_n;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, rx;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, r;
  int          mismatches = 0;
  int          n_checks = 0;

  // 25 MHz reference clock
  always #20 clk = ~clk;

  adcsp_host_model i_host (.i_ref_clk(clk), .i_dout(dout), .i_dout_oe_n(oe_n),
    .o_sclk(sclk), .o_din(din), .o_cs_n(cs_n));

  adcsp_top i_dut (.i_ref_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_din(din), .i_cs_n(cs_n),
    .o_dout(dout), .o_dout_oe_n(oe_n), .o_result_ready_n(rdy_n),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  task automatic tmo();
    mismatches++;
    $display("BAD wait exp handshake got none");
    finish_test();
  endtask : tmo

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'h1; wdata <= v; wvalid <= 1'h1; bready <= 1'h1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin rs = bresp; bready <= 1'h0; break; end
    end
    if (k == 40) tmo();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge clk);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin v = rdata; rs = rresp; rready <= 1'h0; break; end
    end
    if (k == 40) tmo();
  endtask : axi_rd

  task automatic hb(input logic [7:0] b);
    i_host.shift({24'h0, b}, 8, rx);
  endtask : hb

  // outputs right after reset
  task automatic t_reset();
    `CHK("ready pin", 1'h1, rdy_n)
    `CHK("dout enable", 1'h1, oe_n)
    `CHK("awready", 1'h1, awready)
    `CHK("arready", 1'h1, arready)
  endtask : t_reset

  // clock and setup writes, calibration flag, bus errors
  task automatic t_setup();
    hb(8'h20); hb(8'h0C); hb(8'h10); hb(8'h40); i_host.drop();
    axi_rd(`ADCSP_OFF_CLOCK, d, r);
    `CHK("clock reg", 8'h0C, d[7:0])
    axi_rd(`ADCSP_OFF_SETUP, d, r);
    `CHK("setup reg", 8'h40, d[7:0])
    axi_rd(`ADCSP_OFF_COMM, d, r);
    `CHK("comm reg", 7'h10, d[6:0])
    axi_rd(`ADCSP_OFF_STATUS, d, r);
    `CHK("cal flag", 1'h1, d[`ADCSP_ST_CAL])
    axi_wr(`ADCSP_OFF_STATUS, 32'h2, r);
    axi_rd(`ADCSP_OFF_STATUS, d, r);
    `CHK("cal clear", 1'h0, d[`ADCSP_ST_CAL])
    axi_wr(8'h40, 32'h1, r);
    `CHK("unmapped wr", `ADCSP_RESP_SLVERR, r)
    axi_rd(8'h44, d, r);
    `CHK("unmapped rd", `ADCSP_RESP_SLVERR, r)
    `CHK("unmapped data", 32'h0, d)
  endtask : t_setup

  // new result, ready pin and bit, 16 bit read with noise on din
  task automatic t_read();
    int k;
    axi_wr(`ADCSP_OFF_SAMPLE, 32'hA5C3, r);
    for (k = 0; k < 20 && rdy_n !== 1'h0; k++) @(posedge clk);
    `CHK("ready low", 1'h0, rdy_n)
    if (rdy_n !== 1'h0) tmo();
    hb(8'h08); i_host.shift(32'hFF, 8, rx);
    `CHK("comm ready bit", 1'h0, rx[7])
    hb(8'h38); i_host.shift(32'h2099, 16, rx);
    `CHK("data word", 16'hA5C3, rx[15:0])
    i_host.tick(6);
    `CHK("ready high", 1'h1, rdy_n)
    hb(8'h08); i_host.shift(32'hFF, 8, rx);
    `CHK("comm idle bit", 1'h1, rx[7])
    i_host.drop();
    axi_rd(`ADCSP_OFF_CLOCK, d, r);
    `CHK("din ignored", 8'h0C, d[7:0])
  endtask : t_read

  // 32 ones in mid comm byte bring the port back to comm
  task automatic t_ones();
    hb(8'h77); i_host.shift(32'hFFFFFFFF, 29, rx);
    hb(8'h20); hb(8'h05); i_host.drop();
    axi_rd(`ADCSP_OFF_CLOCK, d, r);
    `CHK("resync", 8'h05, d[7:0])
    // 24 bit register written and read back whole
    hb(8'h60); i_host.shift(32'h123456, 24, rx);
    hb(8'h68); i_host.shift(32'h0, 24, rx);
    `CHK("wide reg", 24'h123456, rx[23:0])
    i_host.drop();
  endtask : t_ones

  // main sequence
  initial begin
    awaddr = 8'h0; awvalid = 1'h0; wdata = 32'h0; wvalid = 1'h0; bready = 1'h0;
    araddr = 8'h0; arvalid = 1'h0; rready = 1'h0;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_setup();
    t_read();
    t_ones();
    finish_test();
  end
endmodule : tb
`default_nettype wire
